// ---- src/etpm_params.svh ----
// Constants of the Ethernet test port monitor core.
// Assumes inclusion by bare name from the package and the top module.
// Summary of operation
// RL1: Endpoint mode only, no pass-through paths
// RL2: Dynamic mode takes server-assigned addresses
// RL3: Static mode uses user source, gateway, mask
// RL4: Reject all-zeros or all-ones IP entries
// RL5: Load selector: off, ping, traffic generation
// RL6: Traffic load rate 1 kbps to 10000
// RL7: Traffic packet length 70 to 1518 bytes
// RL8: Link indicator lit while link detected
// RL9: Receive indicator lit while data arrives
// RL10: Contention indicator lit on collision
// RL11: Sticky collision result flag per test
// RL12: Count frames failing checksum check
// RL13: Count frames under 64 bits
// RL14: Count frames over 1518 bytes
// RL15: Count receive overflows losing data
// RL16: Summary lists faults or reports good
// RL17: Count frames with bit count misaligned
// RL18: Counters clear on start, saturate high
`ifndef ETPM_PARAMS_SVH
`define ETPM_PARAMS_SVH
`define ETPM_IP_ZERO        32'h0000_0000
`define ETPM_IP_ONES        32'hFFFF_FFFF
`define ETPM_RATE_MIN_KBPS  14'h0001
`define ETPM_RATE_MAX_KBPS  14'h2710
`define ETPM_LEN_MIN        11'h046
`define ETPM_LEN_MAX        11'h5EE
`define ETPM_MIN_FRAME_BITS 14'h0040
`define ETPM_CRC_INIT       32'hFFFF_FFFF
`define ETPM_CRC_POLY       32'hEDB8_8320
`define ETPM_CRC_RESIDUE    32'hDEBB_20E3
`define ETPM_FIFO_DEPTH     32
`define ETPM_CNT_WIDTH      16
// Fault vector bit positions
`define ETPM_F_CSUM  0
`define ETPM_F_SHORT 1
`define ETPM_F_LONG  2
`define ETPM_F_OVFL  3
`define ETPM_F_ALIGN 4
`define ETPM_F_COLL  5
`define ETPM_F_CFG   6
`endif

// ---- src/etpm_pkg.sv ----
// Types shared by the Ethernet test port monitor core.
// Assumes etpm_params.svh is on the include path.
`include "etpm_params.svh"
package etpm_pkg;
  typedef enum logic [1:0] {
    ETPM_LOAD_OFF     = 2'h0,
    ETPM_LOAD_PING    = 2'h1,
    ETPM_LOAD_TRAFFIC = 2'h2
  } etpm_load_t;

  typedef enum logic [2:0] {
    ETPM_ST_IDLE  = 3'b001,
    ETPM_ST_FRAME = 3'b010,
    ETPM_ST_DROP  = 3'b100
  } etpm_state_t;

  // One received byte; extra counts dribble bits after the last byte
  typedef struct packed {
    logic       last;
    logic [2:0] extra;
    logic [7:0] data;
  } etpm_rx_word_t;

  typedef struct packed {
    logic src;
    logic gw;
    logic dest;
    logic sel;
    logic rate;
    logic len;
  } etpm_cfg_err_t;
endpackage : etpm_pkg

// ---- src/etpm_top.sv ----
// Ethernet test port monitor: settings check, receive frame statistics,
// indicators. Assumes an upstream decoder delivers received bytes on CLK
// and that LINK, CRS and COL pins are asynchronous to CLK.
`timescale 1ns/1ps
`include "etpm_params.svh"

module etpm_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = `ETPM_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : etpm_fifo

module etpm_top
  import etpm_pkg::*;
#(
  parameter int CW = `ETPM_CNT_WIDTH
) (
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  input  wire logic          CE,
  input  wire logic          TEST_START,
  input  wire logic          ADDR_DYNAMIC,
  input  wire logic [31:0]   SRC_IP,
  input  wire logic [31:0]   GW_IP,
  input  wire logic [31:0]   SUBNET_MASK,
  input  wire logic [31:0]   DEST_IP,
  input  wire logic          DHCP_VALID,
  input  wire logic [31:0]   DHCP_IP,
  input  wire logic [31:0]   DHCP_GW,
  input  wire logic [31:0]   DHCP_MASK,
  input  wire logic [1:0]    LOAD_SEL,
  input  wire logic [13:0]   LOAD_RATE_KBPS,
  input  wire logic [10:0]   PKT_LEN,
  input  wire logic          LINK_PIN,
  input  wire logic          CRS_PIN,
  input  wire logic          COL_PIN,
  input  wire logic          RX_VALID,
  output logic               RX_READY,
  input  wire logic [7:0]    RX_DATA,
  input  wire logic          RX_LAST,
  input  wire logic [2:0]    RX_EXTRA_BITS,
  input  wire logic          RX_HOLD,
  output logic [31:0]        ACTIVE_SRC_IP,
  output logic [31:0]        ACTIVE_GW_IP,
  output logic [31:0]        ACTIVE_MASK,
  output logic [5:0]         CFG_ERR,
  output logic               CFG_OK,
  output logic [1:0]         LOAD_MODE,
  output logic               LED_LINK,
  output logic               LED_RX,
  output logic               CONTENTION_INDICATOR,
  output logic               COLLISION_FLAG,
  output logic [CW-1:0]      CHECKSUM_FAIL_FRAME_COUNT,
  output logic [CW-1:0]      UNDERSIZE_COUNT,
  output logic [CW-1:0]      OVERSIZE_COUNT,
  output logic [CW-1:0]      OVERFLOW_COUNT,
  output logic [CW-1:0]      ALIGN_ERR_COUNT,
  output logic [6:0]         SUMMARY_FAULTS,
  output logic               ALL_GOOD
);
  function automatic logic bad_ip(input logic [31:0] ip);
    return (ip == `ETPM_IP_ZERO) || (ip == `ETPM_IP_ONES);
  endfunction : bad_ip

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (v == '1) ? v : v + 1'b1; // RL18
  endfunction : sat_inc

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `ETPM_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Pin synchronisers; a level is taken once stages two and three agree
  logic [2:0] link_s_r, crs_s_r, col_s_r;
  logic       link_r, crs_r, col_r;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      link_s_r <= 3'h0;
      crs_s_r  <= 3'h0;
      col_s_r  <= 3'h0;
      link_r   <= 1'b0;
      crs_r    <= 1'b0;
      col_r    <= 1'b0;
    end else if (CE) begin
      link_s_r <= {link_s_r[1:0], LINK_PIN};
      crs_s_r  <= {crs_s_r[1:0], CRS_PIN};
      col_s_r  <= {col_s_r[1:0], COL_PIN};
      if (link_s_r[1] == link_s_r[2]) link_r <= link_s_r[2];
      if (crs_s_r[1] == crs_s_r[2])   crs_r  <= crs_s_r[2];
      if (col_s_r[1] == col_s_r[2])   col_r  <= col_s_r[2];
    end
  end

  // Settings check and effective addressing
  etpm_cfg_err_t err_nxt;
  logic [1:0]    load_nxt;

  always_comb begin
    err_nxt      = '0;
    err_nxt.src  = !ADDR_DYNAMIC && bad_ip(SRC_IP); // RL4
    err_nxt.gw   = !ADDR_DYNAMIC && bad_ip(GW_IP); // RL4
    err_nxt.dest = (LOAD_SEL != ETPM_LOAD_OFF) && bad_ip(DEST_IP); // RL4
    err_nxt.sel  = (LOAD_SEL != ETPM_LOAD_OFF) &&
                   (LOAD_SEL != ETPM_LOAD_PING) &&
                   (LOAD_SEL != ETPM_LOAD_TRAFFIC); // RL5
    err_nxt.rate = (LOAD_SEL == ETPM_LOAD_TRAFFIC) &&
                   ((LOAD_RATE_KBPS < `ETPM_RATE_MIN_KBPS) ||
                    (LOAD_RATE_KBPS > `ETPM_RATE_MAX_KBPS)); // RL6
    err_nxt.len  = (LOAD_SEL == ETPM_LOAD_TRAFFIC) &&
                   ((PKT_LEN < `ETPM_LEN_MIN) ||
                    (PKT_LEN > `ETPM_LEN_MAX)); // RL7
    // Invalid settings hold the transmitter off rather than send junk
    load_nxt = (err_nxt != '0) ? ETPM_LOAD_OFF : LOAD_SEL; // RL5
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CFG_ERR   <= '0;
      CFG_OK    <= 1'b0;
      LOAD_MODE <= ETPM_LOAD_OFF;
    end else if (CE) begin
      CFG_ERR   <= err_nxt;
      CFG_OK    <= (err_nxt == '0);
      LOAD_MODE <= load_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ACTIVE_SRC_IP <= `ETPM_IP_ZERO;
      ACTIVE_GW_IP  <= `ETPM_IP_ZERO;
      ACTIVE_MASK   <= `ETPM_IP_ZERO;
    end else if (CE) begin
      if (ADDR_DYNAMIC) begin
        // Keeps the previous address (zero after reset) until the server answers
        if (DHCP_VALID) begin
          ACTIVE_SRC_IP <= DHCP_IP; // RL2
          ACTIVE_GW_IP  <= DHCP_GW; // RL2
          ACTIVE_MASK   <= DHCP_MASK; // RL2
        end
      end else begin
        ACTIVE_SRC_IP <= SRC_IP; // RL3
        ACTIVE_GW_IP  <= GW_IP; // RL3
        ACTIVE_MASK   <= SUBNET_MASK; // RL3
      end
    end
  end

  // Receive buffer; overflow when the upstream offers a byte we cannot take
  etpm_rx_word_t in_w, out_w;
  logic          in_rdy, out_vld, pop;

  assign in_w = '{last: RX_LAST, extra: RX_EXTRA_BITS, data: RX_DATA};
  assign pop  = out_vld && !RX_HOLD;

  etpm_fifo #(
    .W     ($bits(etpm_rx_word_t)),
    .DEPTH (`ETPM_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .ce        (CE),
    .in_valid  (RX_VALID),
    .in_ready  (in_rdy),
    .in_data   (in_w),
    .out_valid (out_vld),
    .out_ready (!RX_HOLD),
    .out_data  (out_w)
  );

  // Frames end here; nothing is forwarded or looped back
  etpm_state_t st_r;
  logic [31:0] crc_r, crc_nxt;
  logic [10:0] len_r;
  logic [14:0] bits_nxt;
  logic        ovfl_ev;
  logic        first_byte_lost;

  assign ovfl_ev         = RX_VALID && !in_rdy; // RL15
  assign crc_nxt         = crc_byte(crc_r, out_w.data);
  // Wide enough that a saturated length cannot wrap into a short frame
  assign bits_nxt        = {1'b0, len_r, 3'h0} + 15'h0008 + 15'(out_w.extra);
  assign first_byte_lost = ovfl_ev && RX_LAST;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_r  <= ETPM_ST_IDLE;
      crc_r <= `ETPM_CRC_INIT;
      len_r <= '0;
    end else if (CE && pop) begin
      case (st_r) // RL1
        ETPM_ST_IDLE, ETPM_ST_FRAME: begin
          crc_r <= out_w.last ? `ETPM_CRC_INIT : crc_nxt;
          len_r <= out_w.last ? '0 : ((len_r == '1) ? len_r
                                                    : len_r + 1'b1);
          st_r  <= out_w.last ? ETPM_ST_IDLE : ETPM_ST_FRAME;
        end
        default: begin
          crc_r <= `ETPM_CRC_INIT;
          len_r <= '0;
          st_r  <= ETPM_ST_IDLE;
        end
      endcase
    end
  end

  logic fr_end, fr_csum, fr_short, fr_long, fr_align;

  assign fr_end   = CE && pop && out_w.last;
  assign fr_csum  = fr_end && (crc_nxt != `ETPM_CRC_RESIDUE);
  assign fr_short = fr_end && (bits_nxt < `ETPM_MIN_FRAME_BITS);
  assign fr_long  = fr_end && (len_r >= `ETPM_LEN_MAX);
  assign fr_align = fr_end && (out_w.extra != 3'h0);

  always_ff @(posedge CLK) begin
    if (!RESET_N || (CE && TEST_START)) begin
      CHECKSUM_FAIL_FRAME_COUNT <= '0; // RL18
      UNDERSIZE_COUNT           <= '0;
      OVERSIZE_COUNT            <= '0;
      OVERFLOW_COUNT            <= '0;
      ALIGN_ERR_COUNT           <= '0;
    end else if (CE) begin
      if (fr_csum)
        CHECKSUM_FAIL_FRAME_COUNT <= sat_inc(CHECKSUM_FAIL_FRAME_COUNT); // RL12
      if (fr_short) UNDERSIZE_COUNT <= sat_inc(UNDERSIZE_COUNT); // RL13
      if (fr_long)  OVERSIZE_COUNT  <= sat_inc(OVERSIZE_COUNT); // RL14
      if (ovfl_ev)  OVERFLOW_COUNT  <= sat_inc(OVERFLOW_COUNT); // RL15
      if (fr_align) ALIGN_ERR_COUNT <= sat_inc(ALIGN_ERR_COUNT); // RL17
    end
  end

  // A collision in the clearing cycle still counts: set beats clear
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      COLLISION_FLAG <= 1'b0;
    end else if (CE) begin
      if (col_r)           COLLISION_FLAG <= 1'b1; // RL11
      else if (TEST_START) COLLISION_FLAG <= 1'b0; // RL18
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      LED_LINK             <= 1'b0;
      LED_RX               <= 1'b0;
      CONTENTION_INDICATOR <= 1'b0;
      RX_READY             <= 1'b0;
    end else if (CE) begin
      LED_LINK             <= link_r; // RL8
      LED_RX               <= crs_r || (st_r == ETPM_ST_FRAME); // RL9
      CONTENTION_INDICATOR <= col_r; // RL10
      RX_READY             <= in_rdy && !first_byte_lost;
    end
  end

  // Summary: one bit per out-of-spec result, good only when all clear
  logic [6:0] flt_nxt;

  always_comb begin
    flt_nxt                = '0;
    flt_nxt[`ETPM_F_CSUM]  = (CHECKSUM_FAIL_FRAME_COUNT != '0);
    flt_nxt[`ETPM_F_SHORT] = (UNDERSIZE_COUNT != '0);
    flt_nxt[`ETPM_F_LONG]  = (OVERSIZE_COUNT != '0);
    flt_nxt[`ETPM_F_OVFL]  = (OVERFLOW_COUNT != '0);
    flt_nxt[`ETPM_F_ALIGN] = (ALIGN_ERR_COUNT != '0);
    flt_nxt[`ETPM_F_COLL]  = COLLISION_FLAG;
    flt_nxt[`ETPM_F_CFG]   = !CFG_OK;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      SUMMARY_FAULTS <= '0;
      ALL_GOOD       <= 1'b0;
    end else if (CE) begin
      SUMMARY_FAULTS <= flt_nxt; // RL16
      ALL_GOOD       <= (flt_nxt == '0); // RL16
    end
  end
endmodule : etpm_top

// ---- verification/etpm_monitor.sv ----
// Checker for the Ethernet test port monitor core.
// Assumes it is bound to etpm_top and sees only its ports.
`timescale 1ns/1ps
module etpm_monitor #(
  parameter int CW = 16
) (
  input wire logic          CLK,
  input wire logic          RESET_N,
  input wire logic          CE,
  input wire logic          TEST_START,
  input wire logic          ADDR_DYNAMIC,
  input wire logic [31:0]   SRC_IP,
  input wire logic          DHCP_VALID,
  input wire logic [31:0]   DHCP_IP,
  input wire logic [1:0]    LOAD_SEL,
  input wire logic [10:0]   PKT_LEN,
  input wire logic [31:0]   ACTIVE_SRC_IP,
  input wire logic [5:0]    CFG_ERR,
  input wire logic [1:0]    LOAD_MODE,
  input wire logic          COLLISION_FLAG,
  input wire logic [CW-1:0] CHECKSUM_FAIL_FRAME_COUNT,
  input wire logic [6:0]    SUMMARY_FAULTS,
  input wire logic          ALL_GOOD
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_src_bad;
    CE && !ADDR_DYNAMIC && (SRC_IP == '0 || SRC_IP == '1) |=> CFG_ERR[5];
  endproperty
  a_src_bad: assert property (p_src_bad) else $error("bad source kept");
  property p_load_off;
    CFG_ERR != 6'h00 |-> LOAD_MODE == 2'h0;
  endproperty
  a_load_off: assert property (p_load_off) else $error("load not off");
  property p_len;
    CE && LOAD_SEL == 2'h2 && PKT_LEN > 11'h5EE |=> CFG_ERR[0];
  endproperty
  a_len: assert property (p_len) else $error("long length kept");
  property p_dhcp;
    CE && ADDR_DYNAMIC && DHCP_VALID |=> ACTIVE_SRC_IP == $past(DHCP_IP);
  endproperty
  a_dhcp: assert property (p_dhcp) else $error("server address lost");
  property p_static;
    CE && !ADDR_DYNAMIC |=> ACTIVE_SRC_IP == $past(SRC_IP);
  endproperty
  a_static: assert property (p_static) else $error("user address lost");
  property p_coll;
    CE && !TEST_START && COLLISION_FLAG |=> COLLISION_FLAG;
  endproperty
  a_coll: assert property (p_coll) else $error("collision flag fell");
  property p_sat;
    CE && !TEST_START && &CHECKSUM_FAIL_FRAME_COUNT
      |=> &CHECKSUM_FAIL_FRAME_COUNT;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");
  property p_good;
    ALL_GOOD |-> SUMMARY_FAULTS == 7'h00;
  endproperty
  a_good: assert property (p_good) else $error("good with faults");
  property p_csum_fault;
    CE && CHECKSUM_FAIL_FRAME_COUNT != '0
      |=> !ALL_GOOD && SUMMARY_FAULTS[0];
  endproperty
  a_csum_fault: assert property (p_csum_fault)
    else $error("fault hidden");

  c_coll: cover property (COLLISION_FLAG);
  c_sat: cover property (&CHECKSUM_FAIL_FRAME_COUNT);
  c_dhcp: cover property (CE && ADDR_DYNAMIC && DHCP_VALID);
endmodule : etpm_monitor

bind etpm_top etpm_monitor #(.CW(CW)) u_mon (.*);

// ---- verification/etpm_net_dev.sv ----
// Network device model feeding received frames to the core.
// Assumes send is entered just after a rising clk edge.
`timescale 1ns/1ps
module etpm_net_dev (
  input  wire logic  clk,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_last,
  output logic [2:0] rx_extra,
  output logic       crs
);
  initial begin
    {rx_valid, rx_last, crs} = 3'h0;
    rx_data  = 8'h00;
    rx_extra = 3'h0;
  end

  // Bad frames send the raw remainder, so the check never matches
  task automatic send(input int n, input bit good, input logic [2:0] xb);
    logic [31:0] c;
    logic [31:0] f;
    logic [7:0]  b;
    c = 32'hFFFF_FFFF;
    crs = 1'b1;
    for (int i = 0; i < n; i++) begin
      b = 8'(i * 37);
      if (i < n - 4) begin
        for (int k = 0; k < 8; k++) begin
          f = c[0] ^ b[k] ? 32'hEDB8_8320 : 32'h0000_0000;
          c = (c >> 1) ^ f;
        end
      end else begin
        f = good ? ~c : c;
        b = f[8 * (i - n + 4) +: 8];
      end
      rx_data  = b;
      rx_valid = 1'b1;
      rx_last  = (i == n - 1);
      rx_extra = rx_last ? xb : 3'h0;
      @(posedge clk);
      #1;
    end
    {rx_valid, rx_last, crs} = 3'h0;
    rx_data = ~rx_data;
  endtask : send
endmodule : etpm_net_dev

// ---- verification/testbench.sv ----
// Self-checking bench for the Ethernet test port monitor core.
// Assumes etpm_top, etpm_net_dev and the bound checker are compiled.
`timescale 1ns/1ps
module testbench;
  localparam int CW = 4;
  logic          CLK, RESET_N, CE, TEST_START, ADDR_DYNAMIC, DHCP_VALID;
  logic          LINK_PIN, CRS_PIN, COL_PIN, RX_VALID, RX_READY, RX_LAST;
  logic          RX_HOLD, CFG_OK, LED_LINK, LED_RX, CONTENTION_INDICATOR;
  logic          COLLISION_FLAG, ALL_GOOD;
  logic [31:0]   SRC_IP, GW_IP, SUBNET_MASK, DEST_IP, DHCP_IP, DHCP_GW;
  logic [31:0]   DHCP_MASK, ACTIVE_SRC_IP, ACTIVE_GW_IP, ACTIVE_MASK;
  logic [1:0]    LOAD_SEL, LOAD_MODE;
  logic [13:0]   LOAD_RATE_KBPS;
  logic [10:0]   PKT_LEN;
  logic [7:0]    RX_DATA;
  logic [2:0]    RX_EXTRA_BITS;
  logic [5:0]    CFG_ERR;
  logic [6:0]    SUMMARY_FAULTS;
  logic [CW-1:0] CHECKSUM_FAIL_FRAME_COUNT, UNDERSIZE_COUNT, OVERSIZE_COUNT;
  logic [CW-1:0] OVERFLOW_COUNT, ALIGN_ERR_COUNT;
  int            n_errors = 0;
  int            check_count = 0;
  int            cyc = 0;
  logic [31:0]   ips [3] = '{32'h0A00_0001, 32'h0000_0000, 32'hFFFF_FFFF};
  // Select, rate, length, source, destination, error bits
  int crow [13][6] = '{'{0, 0, 0, 0, 1, 0}, '{1, 0, 0, 0, 0, 0},
    '{1, 0, 0, 0, 2, 8}, '{2, 1, 70, 0, 0, 0}, '{2, 10000, 1518, 0, 0, 0},
    '{2, 0, 70, 0, 0, 2}, '{2, 10001, 70, 0, 0, 2}, '{2, 1, 69, 0, 0, 1},
    '{2, 1, 1519, 0, 0, 1}, '{3, 1, 70, 0, 0, 4}, '{2, 1, 70, 1, 0, 32},
    '{2, 1, 70, 2, 0, 32}, '{2, 1, 70, 0, 0, 0}};
  // Bytes, good check, extra bits, then running counters
  int frow [8][7] = '{'{64, 1, 0, 0, 0, 0, 0}, '{64, 0, 0, 1, 0, 0, 0},
    '{7, 0, 0, 2, 1, 0, 0}, '{8, 1, 0, 2, 1, 0, 0}, '{1519, 1, 0, 2, 1, 1, 0},
    '{1518, 1, 0, 2, 1, 1, 0}, '{64, 1, 3, 2, 1, 1, 1},
    '{7, 1, 7, 2, 2, 1, 2}};

  etpm_top #(.CW(CW)) dut (.*);
  etpm_net_dev dev (.clk(CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
                    .rx_last(RX_LAST), .rx_extra(RX_EXTRA_BITS),
                    .crs(CRS_PIN));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // Whole run needs about 5000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {RESET_N, TEST_START, ADDR_DYNAMIC, DHCP_VALID, LINK_PIN} = 5'h00;
    {COL_PIN, RX_HOLD, CE} = 3'h1;
    {GW_IP, SUBNET_MASK} = {32'h0A00_0002, 32'hFFFF_FF00};
    {DHCP_IP, DHCP_GW} = {32'h0A00_0009, 32'h0A00_0001};
    DHCP_MASK = 32'hFFFF_0000;
    {SRC_IP, DEST_IP} = {ips[0], ips[0]};
    {LOAD_SEL, LOAD_RATE_KBPS, PKT_LEN} = {2'h0, 14'h0001, 11'h046};
    tick(12);
    check(32'(ALL_GOOD), 0);
    RESET_N = 1'b1;
    tick(6);
    check(32'(LED_LINK), 0);
    check(32'(RX_READY), 1);
    LINK_PIN = 1'b1;
    foreach (crow[i]) begin
      LOAD_SEL = 2'(crow[i][0]);
      LOAD_RATE_KBPS = 14'(crow[i][1]);
      PKT_LEN = 11'(crow[i][2]);
      SRC_IP = ips[crow[i][3]];
      DEST_IP = ips[crow[i][4]];
      tick(2);
      check(32'(CFG_ERR), crow[i][5]);
      check(32'(LOAD_MODE), crow[i][5] != 0 ? 0 : crow[i][0]);
      check(32'(CFG_OK), 32'(crow[i][5] == 0));
    end
    GW_IP = 32'hFFFF_FFFF;
    tick(2);
    check(32'(CFG_ERR), 16);
    GW_IP = 32'h0A00_0002;
    {ADDR_DYNAMIC, DHCP_VALID, SRC_IP} = {2'h3, 32'h0000_0000};
    tick(1);
    DHCP_VALID = 1'b0;
    tick(2);
    check(ACTIVE_SRC_IP, 32'h0A00_0009);
    check(ACTIVE_GW_IP, 32'h0A00_0001);
    check(ACTIVE_MASK, 32'hFFFF_0000);
    check(32'(CFG_ERR), 0);
    {ADDR_DYNAMIC, SRC_IP} = {1'b0, ips[0]};
    tick(2);
    check(ACTIVE_SRC_IP, ips[0]);
    check(ACTIVE_GW_IP, 32'h0A00_0002);
    check(ACTIVE_MASK, 32'hFFFF_FF00);
    check(32'(ALL_GOOD), 1);
    check(32'(LED_LINK), 1);
    CE = 1'b0;
    SRC_IP = 32'h0A00_0005;
    tick(3);
    check(ACTIVE_SRC_IP, ips[0]);
    CE = 1'b1;
    tick(1);
    check(ACTIVE_SRC_IP, 32'h0A00_0005);
    foreach (frow[i]) begin
      dev.send(frow[i][0], frow[i][1], 3'(frow[i][2]));
      tick(4);
      check(32'(CHECKSUM_FAIL_FRAME_COUNT), frow[i][3]);
      check(32'(UNDERSIZE_COUNT), frow[i][4]);
      check(32'(OVERSIZE_COUNT), frow[i][5]);
      check(32'(ALIGN_ERR_COUNT), frow[i][6]);
    end
    check(32'(SUMMARY_FAULTS), 32'h0000_0017);
    fork
      dev.send(200, 1'b1, 3'h0);
      begin
        tick(50);
        check(32'(LED_RX), 1);
      end
    join
    tick(6);
    check(32'(LED_RX), 0);
    COL_PIN = 1'b1;
    tick(6);
    check(32'(CONTENTION_INDICATOR), 1);
    COL_PIN = 1'b0;
    tick(6);
    check(32'(CONTENTION_INDICATOR), 0);
    check(32'(COLLISION_FLAG), 1);
    TEST_START = 1'b1;
    tick(1);
    TEST_START = 1'b0;
    tick(1);
    check(32'(COLLISION_FLAG), 0);
    check(32'(UNDERSIZE_COUNT), 0);
    repeat (17) begin
      dev.send(64, 1'b0, 3'h0);
      tick(1);
    end
    tick(4);
    check(32'(CHECKSUM_FAIL_FRAME_COUNT), 15);
    // Collision arriving while the clear is held must still set the flag
    {TEST_START, COL_PIN} = 2'h3;
    tick(6);
    check(32'(COLLISION_FLAG), 1);
    check(32'(CHECKSUM_FAIL_FRAME_COUNT), 0);
    {TEST_START, COL_PIN} = 2'h0;
    RX_HOLD = 1'b1;
    dev.send(40, 1'b1, 3'h0);
    tick(2);
    check(32'(OVERFLOW_COUNT), 8);
    check(32'(RX_READY), 0);
    {RESET_N, RX_HOLD} = 2'h0;
    tick(2);
    check(32'(OVERFLOW_COUNT), 0);
    check(32'(COLLISION_FLAG), 0);
    RESET_N = 1'b1;
    tick(2);
    check(32'(RX_READY), 1);
    finish_test();
  end
endmodule : testbench
